// *** design/aux_adc_sequence_step_config.sv ***
// Setup register bank for sequencer steps two and three
`timescale 1ns/10ps

// Summary of operation
// R1 - Bit 15 enables the step when set; resets to zero.
// R2 - Bits 14:13 pick gain: 00b one, 01b two, 10b and 11b four.
// R3 - Bit 4 picks negative input: zero analog ground, one analog input seven.
// R4 - Bits 3:0 pick positive input: inputs zero to seven, sensor, ground short.
// R5 - Positive codes from 1000b up choose negative input themselves; bit 4 ignored.
// R6 - Step two setup at 92h, resets to 0002h: disabled, gain one, input two.
// R7 - Step three setup at 93h, same layout, resets to 0003h, input three.
// R8 - Bits 12:5 are reserved, read zero and ignore writes.
module aux_adc_sequence_step_config
  import aux_step_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              clk_en_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  output logic      [DATA_W-1:0] rd_data_o,
  output logic                   step_two_enable_o,
  output logic      [1:0]        step_two_gain_o,
  output logic      [2:0]        step_two_gain_factor_o,
  output logic                   step_two_negative_select_o,
  output logic                   step_two_negative_auto_o,
  output logic      [3:0]        step_two_positive_select_o,
  output logic                   step_three_enable_o,
  output logic      [1:0]        step_three_gain_o,
  output logic      [2:0]        step_three_gain_factor_o,
  output logic                   step_three_negative_select_o,
  output logic                   step_three_negative_auto_o,
  output logic      [3:0]        step_three_positive_select_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_STEPS-1:0][DATA_W-1:0] setup;
    logic [DATA_W-1:0]                rd_data;
    logic [NUM_STEPS-1:0]             enable;
    logic [NUM_STEPS-1:0][1:0]        gain;
    logic [NUM_STEPS-1:0][2:0]        factor;
    logic [NUM_STEPS-1:0]             neg;
    logic [NUM_STEPS-1:0]             neg_auto;
    logic [NUM_STEPS-1:0][3:0]        pos;
    logic                             fresh;     // High until the first enabled edge
  } bank_state_t;

  // Index 0 is step two, index 1 is step three
  localparam logic [NUM_STEPS-1:0][ADDR_W-1:0] STEP_ADDR  = {STEP_THREE_ADDR, STEP_TWO_ADDR};
  localparam logic [NUM_STEPS-1:0][DATA_W-1:0] STEP_RESET = {STEP_THREE_RESET, STEP_TWO_RESET};

  bank_state_t                      st;
  bank_state_t                      next_st;
  logic [NUM_STEPS-1:0][DATA_W-1:0] next_setup;
  logic [NUM_STEPS-1:0]             dec_enable;
  logic [NUM_STEPS-1:0][1:0]        dec_gain;
  logic [NUM_STEPS-1:0][2:0]        dec_factor;
  logic [NUM_STEPS-1:0]             dec_neg;
  logic [NUM_STEPS-1:0]             dec_auto;
  logic [NUM_STEPS-1:0][3:0]        dec_pos;

  // ---------------------------------------------------------------
  // Per step write path and decode
  // ---------------------------------------------------------------

  // Decode works on the next word so outputs track the register exactly
  // Costs a decoder per step ahead of the flops, but keeps every output registered
  for (genvar i = 0; i < NUM_STEPS; i++) begin : g_step
    // Reserved bits dropped at the door, so they always read zero
    assign next_setup[i] = (wr_en_i && (addr_i == STEP_ADDR[i])) ?
                           (wr_data_i & WRITE_MASK) : st.setup[i];   // see R6 see R7 see R8

    step_setup_decode u_decode (
      .setup_i           (next_setup[i]),
      .enable_o          (dec_enable[i]),
      .gain_o            (dec_gain[i]),
      .gain_factor_o     (dec_factor[i]),
      .negative_select_o (dec_neg[i]),
      .negative_auto_o   (dec_auto[i]),
      .positive_select_o (dec_pos[i])
    );
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Read data is zero except in the cycle after a read strobe
  always_comb begin
    next_st          = st;
    next_st.setup    = next_setup;
    next_st.enable   = dec_enable;
    next_st.gain     = dec_gain;
    next_st.factor   = dec_factor;
    next_st.neg      = dec_neg;
    next_st.neg_auto = dec_auto;
    next_st.pos      = dec_pos;
    next_st.rd_data  = '0;
    next_st.fresh    = 1'b0;
    if (rd_en_i) begin
      for (int k = 0; k < NUM_STEPS; k++) begin
        if (addr_i == STEP_ADDR[k]) begin
          next_st.rd_data = st.setup[k];
        end
      end
    end
  end

  // Reset loads the default channel per step; enable low freezes all
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st           <= '0;
      st.setup     <= STEP_RESET;                                // see R6 see R7
      st.factor[0] <= GAIN_FACTOR_1;
      st.factor[1] <= GAIN_FACTOR_1;
      st.pos[0]    <= STEP_TWO_RESET[POS_HI:POS_LO];
      st.pos[1]    <= STEP_THREE_RESET[POS_HI:POS_LO];
      st.fresh     <= 1'b1;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign rd_data_o                    = st.rd_data;
  assign step_two_enable_o            = st.enable[0];
  assign step_two_gain_o              = st.gain[0];
  assign step_two_gain_factor_o       = st.factor[0];
  assign step_two_negative_select_o   = st.neg[0];
  assign step_two_negative_auto_o     = st.neg_auto[0];
  assign step_two_positive_select_o   = st.pos[0];
  assign step_three_enable_o          = st.enable[1];
  assign step_three_gain_o            = st.gain[1];
  assign step_three_gain_factor_o     = st.factor[1];
  assign step_three_negative_select_o = st.neg[1];
  assign step_three_negative_auto_o   = st.neg_auto[1];
  assign step_three_positive_select_o = st.pos[1];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // All checks run on the bank clock; reset cancels any attempt in flight
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  reset_value_two_a : assert property (st.fresh |-> st.setup[0] == STEP_TWO_RESET  // see R6
    && !step_two_enable_o && step_two_positive_select_o == 4'h2)
    else $error("step two setup not at its reset value");
  reset_value_three_a : assert property (st.fresh |->  // see R7
    st.setup[1] == STEP_THREE_RESET && step_three_positive_select_o == 4'h3)
    else $error("step three setup not at its reset value");

  unmapped_read_zero_a : assert property (clk_en_i && rd_en_i && addr_i != STEP_TWO_ADDR  // see R8
    && addr_i != STEP_THREE_ADDR |=> rd_data_o == '0)
    else $error("unmapped read returned nonzero data");
  idle_read_zero_a : assert property (clk_en_i && !rd_en_i |=> rd_data_o == '0)  // see R8
    else $error("read data present without a read strobe");

  // Clock enable low must hold every flop, read data included
  freeze_read_a : assert property (!clk_en_i |=> $stable(rd_data_o))
    else $error("read data moved while clock enable low");
  freeze_bank_a : assert property (!clk_en_i |=> $stable(st))
    else $error("bank state moved while clock enable low");

  // A read answer stands one enabled cycle, then the port falls quiet
  // Guards against an answer lingering into the next transfer
  sequence any_read_s;
    clk_en_i && rd_en_i;
  endsequence
  sequence quiet_s;
    clk_en_i && !rd_en_i;
  endsequence
  read_one_cycle_a : assert property (any_read_s ##1 quiet_s |=> rd_data_o == '0)
    else $error("read data stood longer than one cycle");

  for (genvar i = 0; i < NUM_STEPS; i++) begin : g_check
    sequence write_s;
      clk_en_i && wr_en_i && addr_i == STEP_ADDR[i];
    endsequence
    sequence read_s;
      clk_en_i && rd_en_i && addr_i == STEP_ADDR[i];
    endsequence

    write_lands_a : assert property (write_s |=>  // see R1 see R2 see R3 see R4
      st.setup[i] == ($past(wr_data_i) & WRITE_MASK))
      else $error("written setup word not stored");
    write_readback_a : assert property (write_s ##1 read_s |=>  // see R8
      rd_data_o == ($past(wr_data_i, 2) & WRITE_MASK))
      else $error("read back differs from written word");
    hold_no_write_a : assert property (!(clk_en_i && wr_en_i  // see R6 see R7
      && addr_i == STEP_ADDR[i]) |=> $stable(st.setup[i]))
      else $error("setup changed without a write");
    reserved_zero_a : assert property (st.setup[i][RSV_HI:RSV_LO] == '0)  // see R8
      else $error("reserved setup bits not zero");
    enable_follow_a : assert property (st.enable[i] == st.setup[i][ENABLE_BIT])  // see R1
      else $error("step enable does not follow its bit");
    gain_factor_a : assert property (st.factor[i] ==  // see R2
      (st.setup[i][GAIN_HI:GAIN_LO] == 2'h0 ? 3'h1 :
       st.setup[i][GAIN_HI:GAIN_LO] == 2'h1 ? 3'h2 : 3'h4))
      else $error("gain factor wrong for gain code");
    negative_pass_a : assert property (st.pos[i] < 4'h8 |->  // see R3
      st.neg[i] == st.setup[i][NEG_BIT] && !st.neg_auto[i])
      else $error("negative select not passed through");
    negative_auto_a : assert property (st.pos[i] >= 4'h8 |->  // see R5
      !st.neg[i] && st.neg_auto[i])
      else $error("negative select not ignored for internal source");
    positive_follow_a : assert property (st.pos[i] == st.setup[i][POS_HI:POS_LO])  // see R4
      else $error("positive select does not follow its field");
    gain_follow_a : assert property (st.gain[i] == st.setup[i][GAIN_HI:GAIN_LO])  // see R2
      else $error("gain code does not follow its field");
    read_word_a : assert property (read_s |=> rd_data_o == $past(st.setup[i]))  // see R6 see R7
      else $error("read data differs from stored word");
    // A strobe while the clock enable is low is simply not taken
    frozen_write_a : assert property (!clk_en_i && wr_en_i  // see R6 see R7
      && addr_i == STEP_ADDR[i] |=> $stable(st.setup[i]))
      else $error("write taken while clock enable low");
  end

endmodule : aux_adc_sequence_step_config

// *** design/aux_step_pkg.sv ***
// Constants shared by the auxiliary converter step setup bank
package aux_step_pkg;

  // ---------------------------------------------------------------
  // Bus and bank shape
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int NUM_STEPS = 2;

  // ---------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] STEP_TWO_ADDR    = 8'h92;
  localparam logic [ADDR_W-1:0] STEP_THREE_ADDR  = 8'h93;
  localparam logic [DATA_W-1:0] STEP_TWO_RESET   = 16'h0002;
  localparam logic [DATA_W-1:0] STEP_THREE_RESET = 16'h0003;

  // ---------------------------------------------------------------
  // Field layout, identical for every step
  // ---------------------------------------------------------------
  localparam int ENABLE_BIT = 15;
  localparam int GAIN_HI    = 14;
  localparam int GAIN_LO    = 13;
  localparam int RSV_HI     = 12;
  localparam int RSV_LO     = 5;
  localparam int NEG_BIT    = 4;
  localparam int POS_HI     = 3;
  localparam int POS_LO     = 0;

  // Writable bits: enable, gain, negative and positive select
  localparam logic [DATA_W-1:0] WRITE_MASK = 16'he01f;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
  localparam logic [2:0] GAIN_FACTOR_1 = 3'h1;
  localparam logic [2:0] GAIN_FACTOR_2 = 3'h2;
  localparam logic [2:0] GAIN_FACTOR_4 = 3'h4;
  // First positive code whose negative input is picked internally
  localparam logic [3:0] AUTO_NEG_MIN = 4'h8;

endpackage : aux_step_pkg

// *** design/step_setup_decode.sv ***
// Field decoder for one sequencer step setup word
`timescale 1ns/10ps

module step_setup_decode
  import aux_step_pkg::*;
(
  input  wire logic [DATA_W-1:0] setup_i,
  output logic                   enable_o,
  output logic [1:0]             gain_o,
  output logic [2:0]             gain_factor_o,
  output logic                   negative_select_o,
  output logic                   negative_auto_o,
  output logic [3:0]             positive_select_o
);

  // ---------------------------------------------------------------
  // Field split and meaning
  // ---------------------------------------------------------------

  // Plain fields
  assign enable_o          = setup_i[ENABLE_BIT];              // see R1
  assign gain_o            = setup_i[GAIN_HI:GAIN_LO];
  assign positive_select_o = setup_i[POS_HI:POS_LO];           // see R4

  // Internal sources pick their own return path
  assign negative_auto_o   = (setup_i[POS_HI:POS_LO] >= AUTO_NEG_MIN); // see R5
  // Select bit masked so downstream never sees a stale choice
  assign negative_select_o = setup_i[NEG_BIT] & ~negative_auto_o;    // see R3 see R5

  // Codes 10b and 11b both mean gain four
  always_comb begin
    case (setup_i[GAIN_HI:GAIN_LO])
      GAIN_CODE_X1: gain_factor_o = GAIN_FACTOR_1;             // see R2
      GAIN_CODE_X2: gain_factor_o = GAIN_FACTOR_2;             // see R2
      default:      gain_factor_o = GAIN_FACTOR_4;             // see R2
    endcase
  end

endmodule : step_setup_decode

// *** verification/tb_top.sv ***
// Self-checking bench for the step two and three setup register bank
`timescale 1ns/10ps

module tb_top
  import aux_step_pkg::*;
;
  logic              ref_clk_i = 1'b0;
  logic              rstn_i    = 1'b0;
  logic              clk_en_i  = 1'b1;
  logic [ADDR_W-1:0] addr_i    = 8'h00;
  logic [DATA_W-1:0] wr_data_i = 16'h0000;
  logic              wr_en_i   = 1'b0;
  logic              rd_en_i   = 1'b0;
  logic [DATA_W-1:0] rd_data_o;
  logic              s2_en, s2_neg, s2_auto, s3_en, s3_neg, s3_auto;
  logic [1:0]        s2_gain, s3_gain;
  logic [2:0]        s2_fac, s3_fac;
  logic [3:0]        s2_pos, s3_pos;
  int                miscompares = 0;
  int                n_tests     = 0;
  int                cycles      = 0;
  wire  [11:0]       two_o   = {s2_en, s2_gain, s2_fac, s2_neg, s2_auto, s2_pos};
  wire  [11:0]       three_o = {s3_en, s3_gain, s3_fac, s3_neg, s3_auto, s3_pos};

  // Clock at 200 MHz
  always #2.5 ref_clk_i = ~ref_clk_i;

  aux_adc_sequence_step_config i_dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .step_two_enable_o(s2_en), .step_two_gain_o(s2_gain),
    .step_two_gain_factor_o(s2_fac), .step_two_negative_select_o(s2_neg),
    .step_two_negative_auto_o(s2_auto), .step_two_positive_select_o(s2_pos),
    .step_three_enable_o(s3_en), .step_three_gain_o(s3_gain),
    .step_three_gain_factor_o(s3_fac), .step_three_negative_select_o(s3_neg),
    .step_three_negative_auto_o(s3_auto), .step_three_positive_select_o(s3_pos));

  // Expected step outputs for a stored word; auto codes force the negative select low
  function automatic logic [11:0] exp_out(input logic [15:0] w);
    logic [2:0] f;
    f = (w[14:13] == 2'h0) ? 3'h1 : (w[14:13] == 2'h1) ? 3'h2 : 3'h4;
    return {w[15], w[14:13], f, (w[3:0] < 4'h8) & w[4], w[3:0] >= 4'h8, w[3:0]};
  endfunction : exp_out

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_outs(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_outs

  // Write strobe stays up so a following access may come with no gap
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    rd_en_i   <= 1'b0;
    wr_en_i   <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
  endtask : wr

  // Read data is looked at in the one cycle where it stands
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
    rd_en_i <= 1'b1;
    addr_i  <= a;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1 cmp_word(rd_data_o, exp, "read data");
  endtask : rd

  task automatic idle();
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
    rd_en_i <= 1'b0;
  endtask : idle

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin : main
    logic [15:0] d;
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    #1 cmp_outs(two_o, exp_out(16'h0002), "two reset");
    cmp_outs(three_o, exp_out(16'h0003), "three reset");
    rd(STEP_TWO_ADDR, 16'h0002);
    rd(STEP_THREE_ADDR, 16'h0003);
    idle();
    #1 cmp_word(rd_data_o, 16'h0000, "read data idle");
    $display("test reset values done");
    wr(STEP_TWO_ADDR, 16'hffff);
    idle();
    #1 cmp_outs(two_o, exp_out(16'he01f), "two all ones");
    rd(STEP_TWO_ADDR, 16'he01f);
    wr(STEP_TWO_ADDR, 16'h0000);
    idle();
    #1 cmp_outs(two_o, exp_out(16'h0000), "two cleared");
    for (int i = 0; i < 16; i++) begin
      d = {i[0], i[1:0], 8'hff, ~i[0], i[3:0]};
      wr(STEP_THREE_ADDR, d);
      idle();
      #1 cmp_outs(three_o, exp_out(d & 16'he01f), "three fields");
      rd(STEP_THREE_ADDR, d & 16'he01f);
    end
    cmp_outs(two_o, exp_out(16'h0000), "two untouched");
    $display("test field codes done");
    rd(8'h94, 16'h0000);
    rd(8'h91, 16'h0000);
    wr(8'h94, 16'hffff);
    idle();
    rd(STEP_TWO_ADDR, 16'h0000);
    rd(STEP_THREE_ADDR, 16'he00f);
    $display("test unmapped addresses done");
    wr(STEP_THREE_ADDR, 16'h2015);
    rd(STEP_THREE_ADDR, 16'h2015);
    wr(STEP_TWO_ADDR, 16'h4019);
    wr(STEP_THREE_ADDR, 16'h801c);
    rd(STEP_TWO_ADDR, 16'h4019);
    rd(STEP_THREE_ADDR, 16'h801c);
    #1 cmp_outs(two_o, exp_out(16'h4019), "two auto");
    cmp_outs(three_o, exp_out(16'h801c), "three auto");
    $display("test back to back done");
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    wr(STEP_TWO_ADDR, 16'h8000);
    idle();
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    rd(STEP_TWO_ADDR, 16'h4019);
    $display("test clock enable done");
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    #1 cmp_outs(two_o, exp_out(16'h0002), "two second reset");
    cmp_outs(three_o, exp_out(16'h0003), "three second reset");
    rd(STEP_THREE_ADDR, 16'h0003);
    $display("test second reset done");
    test_done();
  end
endmodule : tb_top
